// ---- cap_src.sv ----
// Purpose: signal source model for the four capture pins
// Assumes: pins are push-pull driven by the source, idle low
// Notes: changes land just after a rising edge of sys_clk, the same clock as the sampler
`timescale 1ns/1ps
`default_nettype none
module cap_src (
	// Clock
	input wire logic sys_clk,
	// Pins
	output logic [3:0] cap_pin
);
	// ----------------
	// Pin driver
	// ----------------
	initial cap_pin = 4'h0;
	task automatic drive(input logic [3:0] v);
		@(posedge sys_clk);
		cap_pin <= v;
	endtask
endmodule // cap_src
`default_nettype wire

// ---- capture_channel.sv ----
// Purpose: one capture channel: synchroniser, edge detect, capture register
// Assumes: pin async to sys_clk
// Notes: flag set wins over clear
`timescale 1ns/1ps
`default_nettype none
module capture_channel (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Control
	input wire frt_pkg::edge_mode_t mode,
	input wire logic [15:0] count,
	// Pin
	input wire logic pin,
	// Result
	output logic [15:0] cap_value,
	output logic hit
);
	import frt_pkg::*;
	logic sync_a;
	logic sync_b;
	logic prev;
	logic next_hit;

	// ----------------------------------------
	// Synchroniser
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			prev <= 1'b0;
		end else begin
			sync_a <= pin;
			sync_b <= sync_a;
			prev <= sync_b;
		end
	end

	always_comb begin
		unique case (mode)
			edge_off: next_hit = 1'b0;
			edge_rise: next_hit = sync_b & ~prev;
			edge_fall: next_hit = ~sync_b & prev;
			edge_both: next_hit = sync_b ^ prev;
		endcase
	end
	assign hit = next_hit;

	// ----------------------------------------
	// Capture register
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cap_value <= 16'h0000;
		end else if (next_hit) begin
			cap_value <= count;
		end
	end

	property p_capture;
		@(posedge sys_clk) disable iff (rst)
		hit |=> cap_value == $past(count);
	endproperty
	a_capture: assert property (p_capture) else $error("capture missed count");

	property p_off;
		@(posedge sys_clk) disable iff (rst)
		mode == edge_off |-> !hit;
	endproperty
	a_off: assert property (p_off) else $error("capture while channel off");
endmodule // capture_channel
`default_nettype wire

// ---- free_run_timer.sv ----
// Purpose: 16-bit free-running timer with four capture channels on APB
// Assumes: single clock, synchronous reset, APB3 slave with zero wait states
// Notes: interrupts and transfer-service requests share the status bits
//
// The implementer's own choices: register access over APB and the register addresses.
`include "frt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module free_run_timer #(
	parameter int CW = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Capture pins
	input wire logic [3:0] cap_pin,
	// Requests
	output logic irq,
	output logic [3:0] ovf_irq_num,
	output logic [7:0] ovf_irq_id,
	output logic [4:0] xfer_req
);
	import frt_pkg::*;
	logic [31:0] ctrl;
	logic [CW-1:0] count;
	logic [7:0] cap_ctrl;
	logic [`IRQ_BITS-1:0] irq_stat;
	logic [`IRQ_BITS-1:0] irq_en;
	logic [`IRQ_BITS-1:0] xfer_sel;
	logic [7:0] pre_cnt;
	logic [7:0] div_ratio;
	logic tick;
	logic ovf;
	logic [3:0] hit;
	logic [15:0] cap_value [4];
	logic wr;
	logic rd;
	logic [`IRQ_BITS-1:0] event_vec;
	logic [`IRQ_BITS-1:0] clr_vec;

	function automatic logic is_addr(input logic [11:0] a, input logic [11:0] o);
		return a == o;
	endfunction

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign clr_vec = (wr && is_addr(paddr, `OFS_IRQ_CLR)) ? pwdata[`IRQ_BITS-1:0] : '0;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl <= `CTRL_RESET;
			cap_ctrl <= 8'h00;
			irq_en <= '0;
			xfer_sel <= '0;
		end else if (wr) begin
			if (is_addr(paddr, `OFS_CTRL))
				ctrl <= {27'h0, pwdata[`CTRL_STOP], 2'b00, pwdata[`CTRL_DIV_HI:`CTRL_DIV_LO]};
			if (is_addr(paddr, `OFS_CAP_CTRL))
				cap_ctrl <= pwdata[7:0];
			if (is_addr(paddr, `OFS_IRQ_EN))
				irq_en <= pwdata[`IRQ_BITS-1:0];
			if (is_addr(paddr, `OFS_XFER_SEL))
				xfer_sel <= pwdata[`IRQ_BITS-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (rd && !penable) begin
			unique case (paddr)
				`OFS_CTRL: prdata <= ctrl;
				`OFS_COUNT: prdata <= {16'h0000, count};
				`OFS_CAP_CTRL: prdata <= {24'h0, cap_ctrl};
				`OFS_CAP0: prdata <= {16'h0000, cap_value[0]};
				`OFS_CAP1: prdata <= {16'h0000, cap_value[1]};
				`OFS_CAP2: prdata <= {16'h0000, cap_value[2]};
				`OFS_CAP3: prdata <= {16'h0000, cap_value[3]};
				`OFS_IRQ_STAT: prdata <= {27'h0, irq_stat};
				`OFS_IRQ_EN: prdata <= {27'h0, irq_en};
				`OFS_XFER_SEL: prdata <= {27'h0, xfer_sel};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	always_comb begin
		unique case (ctrl[`CTRL_DIV_HI:`CTRL_DIV_LO])
			2'd0: div_ratio = `DIV0;
			2'd1: div_ratio = `DIV1;
			2'd2: div_ratio = `DIV2;
			2'd3: div_ratio = `DIV3;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst || ctrl[`CTRL_STOP]) begin
			pre_cnt <= 8'h00;
		end else if (pre_cnt >= div_ratio - 8'h01) begin
			pre_cnt <= 8'h00;
		end else begin
			pre_cnt <= pre_cnt + 8'h01;
		end
	end
	assign tick = !ctrl[`CTRL_STOP] && (pre_cnt >= div_ratio - 8'h01);

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	assign ovf = tick && (count == {CW{1'b1}});

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count <= `COUNT_RESET;
		end else if (wr && is_addr(paddr, `OFS_CTRL) && pwdata[`CTRL_CLR]) begin
			count <= `COUNT_RESET;
		end else if (wr && is_addr(paddr, `OFS_COUNT) && ctrl[`CTRL_STOP]) begin
			count <= pwdata[CW-1:0];
		end else if (tick) begin
			count <= count + 1'b1;
		end
	end

	// ----------------------------------------
	// Capture channels
	// ----------------------------------------
	for (genvar i = 0; i < `CAP_CH; i++) begin : g_cap
		capture_channel u_ch (
			.sys_clk(sys_clk),
			.rst(rst),
			.mode(edge_mode_t'(cap_ctrl[2*i+:2])),
			.count(count),
			.pin(cap_pin[i]),
			.cap_value(cap_value[i]),
			.hit(hit[i])
		);
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	assign event_vec = {ovf, hit};

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~clr_vec) | event_vec;
		end
	end

	assign irq = |(irq_stat & irq_en & ~xfer_sel);
	assign xfer_req = irq_stat & irq_en & xfer_sel;
	assign ovf_irq_num = 4'h0;
	assign ovf_irq_id = `IRQ_NUM_OVF;

	// ----------------------------------------
	// Assertion helpers
	// ----------------------------------------
	// Cycles since the last tick; a control write restarts it,
	// since a new ratio may bring the next tick early
	logic [7:0] gap_cnt;
	logic [`IRQ_BITS-1:0] event_vec_d;

	always_ff @(posedge sys_clk) begin
		if (rst || ctrl[`CTRL_STOP] || tick || (wr && is_addr(paddr, `OFS_CTRL))) begin
			gap_cnt <= 8'h00;
		end else begin
			gap_cnt <= gap_cnt + 8'h01;
		end
	end

	// Events of the previous cycle, to check what the flags kept
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			event_vec_d <= '0;
		end else begin
			event_vec_d <= event_vec;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------

	property p_wrap;
		@(posedge sys_clk) disable iff (rst)
		ovf && !wr |=> count == 16'h0000 && irq_stat[`IRQ_OVF];
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap on overflow");

	property p_stopped_hold;
		@(posedge sys_clk) disable iff (rst)
		ctrl[`CTRL_STOP] && !wr |=> $stable(count);
	endproperty
	a_stopped_hold: assert property (p_stopped_hold) else $error("count moved while stopped");

	property p_clear;
		@(posedge sys_clk) disable iff (rst)
		wr && is_addr(paddr, `OFS_CTRL) && pwdata[`CTRL_CLR] |=> count == 16'h0000;
	endproperty
	a_clear: assert property (p_clear) else $error("clear failed");

	sequence s_event;
		|event_vec;
	endsequence

	sequence s_flag_held;
		(irq_stat & event_vec_d) == event_vec_d;
	endsequence

	// Set wins: a clear in the same cycle must not lose the event
	property p_sticky;
		@(posedge sys_clk) disable iff (rst)
		s_event |=> s_flag_held;
	endproperty
	a_sticky: assert property (p_sticky) else $error("event flag lost");

	property p_clr_flag;
		@(posedge sys_clk) disable iff (rst)
		|clr_vec |=> (irq_stat & $past(clr_vec) & ~event_vec_d) == '0;
	endproperty
	a_clr_flag: assert property (p_clr_flag) else $error("flag survived its clear");

	property p_ovf_flag;
		@(posedge sys_clk) disable iff (rst)
		ovf |=> irq_stat[`IRQ_OVF];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

	property p_irq;
		@(posedge sys_clk) disable iff (rst)
		irq_stat[`IRQ_OVF] && irq_en[`IRQ_OVF] && !xfer_sel[`IRQ_OVF]
			|-> irq && !xfer_req[`IRQ_OVF];
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

	property p_xfer_ovf;
		@(posedge sys_clk) disable iff (rst)
		irq_stat[`IRQ_OVF] && irq_en[`IRQ_OVF] && xfer_sel[`IRQ_OVF]
			|-> xfer_req[`IRQ_OVF];
	endproperty
	a_xfer_ovf: assert property (p_xfer_ovf) else $error("overflow transfer missing");

	property p_irq_cap;
		@(posedge sys_clk) disable iff (rst)
		|(irq_stat[3:0] & irq_en[3:0] & ~xfer_sel[3:0]) |-> irq;
	endproperty
	a_irq_cap: assert property (p_irq_cap) else $error("capture interrupt missing");

	property p_xfer_cap;
		@(posedge sys_clk) disable iff (rst)
		|(irq_stat[3:0] & irq_en[3:0] & xfer_sel[3:0]) |-> |xfer_req[3:0];
	endproperty
	a_xfer_cap: assert property (p_xfer_cap) else $error("capture transfer missing");

	property p_irq_quiet;
		@(posedge sys_clk) disable iff (rst)
		!(|(irq_stat & irq_en)) |-> !irq && !(|xfer_req);
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("request without flag");

	// Ticks may come early after a ratio change, never late
	property p_tick_late;
		@(posedge sys_clk) disable iff (rst)
		!ctrl[`CTRL_STOP] |-> gap_cnt < div_ratio;
	endproperty
	a_tick_late: assert property (p_tick_late) else $error("prescaler tick late");

	property p_count_step;
		@(posedge sys_clk) disable iff (rst)
		tick && !wr |=> count == $past(count) + 1'b1;
	endproperty
	a_count_step: assert property (p_count_step) else $error("count did not step");

	property p_load;
		@(posedge sys_clk) disable iff (rst)
		wr && is_addr(paddr, `OFS_COUNT) && ctrl[`CTRL_STOP] |=> count == $past(pwdata[CW-1:0]);
	endproperty
	a_load: assert property (p_load) else $error("stopped load lost");

	property p_read_count;
		@(posedge sys_clk) disable iff (rst)
		rd && !penable && is_addr(paddr, `OFS_COUNT) |=> prdata == {16'h0000, $past(count)};
	endproperty
	a_read_count: assert property (p_read_count) else $error("count read wrong");
endmodule // free_run_timer
`default_nettype wire

// ---- free_run_timer_test.sv ----
// Purpose: self-checking bench for the free-running timer
// Assumes: zero-wait APB slave, 250 MHz clock
// Notes: counter is stopped for captures so values are exact
`include "frt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module free_run_timer_test;
	// ----------------
	// Signals
	// ----------------
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, irq;
	logic [3:0] cap_pin, ovf_irq_num;
	logic [7:0] ovf_irq_id;
	logic [4:0] xfer_req;
	int errors = 0;
	int check_count = 0;
	always #2 sys_clk = ~sys_clk;
	cap_src src_u (.sys_clk(sys_clk), .cap_pin(cap_pin));
	free_run_timer dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cap_pin(cap_pin), .irq(irq), .ovf_irq_num(ovf_irq_num),
		.ovf_irq_id(ovf_irq_id), .xfer_req(xfer_req));
	// ----------------
	// Helpers
	// ----------------
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t %s got %h", $time, m, g);
		end
	endtask
	// Bounded wait on pready; slave latency is not assumed
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50) begin
			errors++;
			report_and_stop;
		end
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_reset;
		apb(0, `OFS_COUNT, 0);
		chk(q <= 32'h4, 1, "count after reset");
		apb(0, `OFS_IRQ_STAT, 0);
		chk(q, 0, "status after reset");
		apb(1, 12'h030, 32'hffff_ffff);
		apb(0, 12'h030, 0);
		chk(q, 0, "unmapped read");
		chk(ovf_irq_id, `IRQ_NUM_OVF, "overflow number");
		chk(ovf_irq_num, 0, "overflow slot");
		chk({pready, pslverr}, 2'b10, "bus response");
		$display("done reset");
	endtask
	// Run for a fixed span at each ratio, then stop and read
	task automatic t_divide;
		int dv[4] = '{`DIV0, `DIV1, `DIV2, `DIV3};
		for (int i = 0; i < 4; i++) begin
			apb(1, `OFS_CTRL, 32'h10 | i);
			apb(1, `OFS_COUNT, 0);
			apb(1, `OFS_CTRL, i);
			repeat (253) @(posedge sys_clk);
			apb(1, `OFS_CTRL, 32'h10 | i);
			apb(0, `OFS_COUNT, 0);
			chk(q + 1 >= 256 / dv[i] && q <= 256 / dv[i] + 1, 1, "ratio");
		end
		apb(1, `OFS_COUNT, 32'h1234);
		apb(0, `OFS_COUNT, 0);
		chk(q, 32'h1234, "load while stopped");
		apb(1, `OFS_CTRL, 32'h3);
		apb(1, `OFS_COUNT, 32'h5555);
		apb(0, `OFS_COUNT, 0);
		chk(q >= 32'h1234 && q <= 32'h1235, 1, "load while running");
		apb(1, `OFS_CTRL, 32'h23);
		apb(0, `OFS_COUNT, 0);
		chk(q <= 32'h1, 1, "clear bit");
		apb(0, `OFS_CTRL, 0);
		chk(q, 32'h3, "clear self-clears");
		$display("done divide");
	endtask
	// Pass 0 routes overflow to irq, pass 1 to the transfer service
	task automatic t_overflow;
		int n;
		for (int p = 0; p < 2; p++) begin
			apb(1, `OFS_XFER_SEL, p ? 32'h10 : 32'h0);
			apb(1, `OFS_CTRL, 32'h10);
			apb(1, `OFS_COUNT, 32'hfffe);
			apb(1, `OFS_IRQ_EN, 32'h10);
			apb(1, `OFS_CTRL, 0);
			n = 0;
			while (irq !== 1'b1 && xfer_req[4] !== 1'b1 && n < 20) begin
				@(posedge sys_clk);
				n++;
			end
			if (n == 20) begin
				errors++;
				report_and_stop;
			end
			chk(irq, !p, "overflow irq");
			chk(xfer_req[4], p, "overflow transfer");
			apb(0, `OFS_COUNT, 0);
			chk(q < 32'h20, 1, "wrap to zero");
			apb(0, `OFS_IRQ_STAT, 0);
			chk(q, 32'h10, "overflow flag");
			apb(1, `OFS_IRQ_CLR, 32'h10);
			apb(0, `OFS_IRQ_STAT, 0);
			chk(q, 0, "flag cleared");
			chk({irq, xfer_req}, 0, "requests released");
		end
		apb(1, `OFS_XFER_SEL, 0);
		$display("done overflow");
	endtask
	// Modes: ch0 rise, ch1 fall, ch2 both, ch3 off
	task automatic t_capture;
		logic [31:0] ex[4] = '{32'h111, 32'h222, 32'h222, 32'h0};
		apb(1, `OFS_CTRL, 32'h10);
		apb(1, `OFS_CAP_CTRL, 32'h2d);
		apb(1, `OFS_IRQ_EN, 32'h0f);
		apb(1, `OFS_COUNT, 32'h111);
		src_u.drive(4'hf);
		repeat (4) @(posedge sys_clk);
		apb(1, `OFS_COUNT, 32'h222);
		src_u.drive(4'h0);
		repeat (4) @(posedge sys_clk);
		for (int c = 0; c < 4; c++) begin
			apb(0, `OFS_CAP0 + 12'(4 * c), 0);
			chk(q, ex[c], "capture value");
		end
		apb(0, `OFS_IRQ_STAT, 0);
		chk(q, 32'h7, "capture flags");
		chk(irq, 1, "capture irq");
		apb(1, `OFS_XFER_SEL, 32'h1);
		apb(0, `OFS_IRQ_STAT, 0);
		chk(xfer_req[0], 1, "capture transfer");
		apb(1, `OFS_IRQ_CLR, 32'h0f);
		apb(0, `OFS_IRQ_STAT, 0);
		chk(q, 0, "capture flags cleared");
		chk(irq, 0, "capture irq released");
		chk(xfer_req[0], 0, "capture transfer released");
		$display("done capture");
	endtask
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset;
		t_divide;
		t_overflow;
		t_capture;
		report_and_stop;
	end
endmodule // free_run_timer_test
`default_nettype wire

// ---- frt_cfg.svh ----
// Purpose: constants for the free-running timer with input capture
// Assumes: APB byte addresses, 32-bit data
// Notes: all offsets and fields as macros
`ifndef FRT_CFG_SVH
`define FRT_CFG_SVH
`define OFS_CTRL 12'h000
`define OFS_COUNT 12'h004
`define OFS_CAP_CTRL 12'h008
`define OFS_CAP0 12'h010
`define OFS_CAP1 12'h014
`define OFS_CAP2 12'h018
`define OFS_CAP3 12'h01c
`define OFS_IRQ_STAT 12'h020
`define OFS_IRQ_EN 12'h024
`define OFS_IRQ_CLR 12'h028
`define OFS_XFER_SEL 12'h02c
`define CTRL_DIV_LO 0
`define CTRL_DIV_HI 1
`define CTRL_STOP 4
`define CTRL_CLR 5
`define CTRL_RESET 32'h0000_0000
`define COUNT_RESET 16'h0000
`define CAP_CH 4
`define IRQ_OVF 4
`define IRQ_BITS 5
`define IRQ_NUM_OVF 8'h13
`define DIV0 8'h01
`define DIV1 8'h04
`define DIV2 8'h10
`define DIV3 8'h40
`endif

// ---- frt_pkg.sv ----
// Purpose: types for the free-running timer
// Assumes: none
// Notes: edge mode encodings
package frt_pkg;
	typedef enum logic [1:0] {
		edge_off = 2'b00,
		edge_rise = 2'b01,
		edge_fall = 2'b11,
		edge_both = 2'b10
	} edge_mode_t;
endpackage
